// ===== include/tsb_pkg.sv
// Purpose: shared constants for the two-wire target front end
// Assumes: 100 MHz core clock
// Notes: address prefixes select the function behind the front end
package tsb_pkg;
	localparam int CLK_MHZ = 100;
	// kept short: sync plus filter delay must stay well inside half a bus
	// clock period, or the ack lands after the host's sampling point
	localparam int GLITCH_NS = 10;
	localparam int GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0] PFX_TEMP = 4'h3;
	localparam logic [3:0] PFX_STORE = 4'hA;
	localparam logic [3:0] PFX_PROT = 4'h6;
	localparam logic [2:0] BIT_MSB = 3'h7;
	localparam logic [2:0] BIT_LSB = 3'h0;
	localparam int FIFO_DEPTH = 16;
	typedef enum logic [1:0] {
		TSB_FN_NONE,
		TSB_FN_TEMP,
		TSB_FN_STORE,
		TSB_FN_PROT
	} tsb_fn_e;
	typedef enum {
		TSB_IDLE,
		TSB_ADDR,
		TSB_ADDR_ACK,
		TSB_WR,
		TSB_WR_ACK,
		TSB_RD,
		TSB_RD_ACK
	} tsb_st_e;
endpackage

// ===== logic/tsb_fifo.sv
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: one clock, synchronous active-low reset
// Notes: full and empty come straight from the word count
`timescale 1ns/10ps
`default_nettype none
module tsb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
	logic [AW:0] cnt_ff, nxt_cnt;
	logic push, pop;
	assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign out_data = mem_ff[rp_ff];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_comb begin
		nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
		nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
		nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wp_ff <= nxt_wp;
			rp_ff <= nxt_rp;
			cnt_ff <= nxt_cnt;
		end
	end
	// storage has no reset: contents are only read while counted valid
	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wp_ff] <= in_data;
		end
	end
endmodule
`default_nettype wire

// ===== logic/tsb_target.sv
// Purpose: two-wire serial bus target front end with address straps
// Assumes: bus pins are asynchronous; clk far faster than 400 kHz
// Notes: received bytes go to a FIFO; read bytes come from rd_* port
`timescale 1ns/10ps
`default_nettype none
module tsb_target #(
	parameter int FIFO_DEPTH = tsb_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic addr_strap_bit_zero,
	input wire logic addr_strap_bit_one,
	input wire logic addr_strap_bit_two,
	input wire logic strap_zero_hv,
	output logic prot_qual,
	input wire logic alarm_req,
	output logic alarm_out,
	output logic alarm_oe,
	output logic [1:0] acc_fn,
	output logic acc_read,
	output logic acc_start,
	output logic acc_stop,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data,
	input wire logic [7:0] rd_data,
	output logic rd_take
);
	localparam int GW = $clog2(tsb_pkg::GLITCH_CYC + 1);
	// three-stage synchronisers; only stages 2 and 3 are compared
	logic [2:0] scl_sy_ff, sda_sy_ff;
	logic scl_ff, sda_ff, nxt_scl, nxt_sda;
	logic [GW-1:0] scl_cnt_ff, sda_cnt_ff, nxt_scl_cnt, nxt_sda_cnt;
	logic scl_rise, scl_fall, start_det, stop_det;
	tsb_pkg::tsb_st_e st_ff, nxt_st;
	logic [7:0] sh_ff, nxt_sh;
	logic [2:0] bit_ff, nxt_bit;
	logic [2:0] strap_ff, nxt_strap;
	logic [1:0] fn_ff, nxt_fn;
	logic rd_ff, nxt_rd, oe_ff, nxt_oe, nack_ff, nxt_nack;
	logic al_ff, hv_ff, start_ff, stop_ff;
	logic push, f_ready;

	function automatic logic [1:0] decode_fn(input logic [3:0] pfx);
		case (pfx)
			tsb_pkg::PFX_TEMP: decode_fn = 2'(tsb_pkg::TSB_FN_TEMP);
			tsb_pkg::PFX_STORE: decode_fn = 2'(tsb_pkg::TSB_FN_STORE);
			tsb_pkg::PFX_PROT: decode_fn = 2'(tsb_pkg::TSB_FN_PROT);
			default: decode_fn = 2'(tsb_pkg::TSB_FN_NONE);
		endcase
	endfunction

	// a level change is accepted only after it stays for GLITCH_CYC + 1 cycles
	always_comb begin
		nxt_scl = scl_ff;
		nxt_sda = sda_ff;
		nxt_scl_cnt = '0;
		nxt_sda_cnt = '0;
		if (scl_sy_ff[1] == scl_sy_ff[2] && scl_sy_ff[2] != scl_ff) begin
			nxt_scl_cnt = scl_cnt_ff + 1'b1;
			if (scl_cnt_ff == GW'(tsb_pkg::GLITCH_CYC)) begin
				nxt_scl = scl_sy_ff[2];
				nxt_scl_cnt = '0;
			end
		end
		if (sda_sy_ff[1] == sda_sy_ff[2] && sda_sy_ff[2] != sda_ff) begin
			nxt_sda_cnt = sda_cnt_ff + 1'b1;
			if (sda_cnt_ff == GW'(tsb_pkg::GLITCH_CYC)) begin
				nxt_sda = sda_sy_ff[2];
				nxt_sda_cnt = '0;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_sy_ff <= 3'h7;
			sda_sy_ff <= 3'h7;
			scl_ff <= 1'b1;
			sda_ff <= 1'b1;
			scl_cnt_ff <= '0;
			sda_cnt_ff <= '0;
		end else begin
			scl_sy_ff <= {scl_sy_ff[1:0], scl_in};
			sda_sy_ff <= {sda_sy_ff[1:0], sda_in};
			scl_ff <= nxt_scl;
			sda_ff <= nxt_sda;
			scl_cnt_ff <= nxt_scl_cnt;
			sda_cnt_ff <= nxt_sda_cnt;
		end
	end
	assign scl_rise = nxt_scl && !scl_ff;
	assign scl_fall = !nxt_scl && scl_ff;
	assign start_det = scl_ff && nxt_scl && sda_ff && !nxt_sda;
	assign stop_det = scl_ff && nxt_scl && !sda_ff && nxt_sda;
	assign push = (st_ff == tsb_pkg::TSB_WR) && scl_rise
		&& bit_ff == tsb_pkg::BIT_LSB && f_ready;

	// bits are taken on bus clock rise, driven after its fall
	always_comb begin
		nxt_st = st_ff;
		nxt_sh = sh_ff;
		nxt_bit = bit_ff;
		nxt_strap = strap_ff;
		nxt_fn = fn_ff;
		nxt_rd = rd_ff;
		nxt_oe = oe_ff;
		nxt_nack = nack_ff;
		if (start_det) begin
			nxt_st = tsb_pkg::TSB_ADDR;
			nxt_bit = tsb_pkg::BIT_MSB;
			nxt_oe = 1'b0;
			nxt_strap = {addr_strap_bit_two, addr_strap_bit_one,
				addr_strap_bit_zero};
		end else if (stop_det) begin
			nxt_st = tsb_pkg::TSB_IDLE;
			nxt_oe = 1'b0;
		end else begin
			case (st_ff)
				tsb_pkg::TSB_IDLE: begin
					nxt_oe = 1'b0;
				end
				tsb_pkg::TSB_ADDR, tsb_pkg::TSB_WR: begin
					if (scl_rise) begin
						nxt_sh = {sh_ff[6:0], sda_ff};
						nxt_bit = bit_ff - 1'b1;
						if (bit_ff == tsb_pkg::BIT_LSB) begin
							nxt_st = (st_ff == tsb_pkg::TSB_ADDR)
								? tsb_pkg::TSB_ADDR_ACK : tsb_pkg::TSB_WR_ACK;
							nxt_nack = (st_ff == tsb_pkg::TSB_WR) && !f_ready;
						end
					end
				end
				tsb_pkg::TSB_ADDR_ACK: begin
					if (scl_fall && !oe_ff) begin
						nxt_fn = decode_fn(sh_ff[7:4]);
						nxt_rd = sh_ff[0];
						if (sh_ff[3:1] == strap_ff
							&& decode_fn(sh_ff[7:4]) != 2'(tsb_pkg::TSB_FN_NONE)) begin
							nxt_oe = 1'b1;
						end else begin
							nxt_st = tsb_pkg::TSB_IDLE;
						end
					end else if (scl_fall) begin
						nxt_oe = 1'b0;
						nxt_bit = tsb_pkg::BIT_MSB;
						nxt_st = rd_ff ? tsb_pkg::TSB_RD : tsb_pkg::TSB_WR;
						if (rd_ff) begin
							nxt_sh = rd_data;
							nxt_oe = !rd_data[7];
						end
					end
				end
				tsb_pkg::TSB_WR_ACK: begin
					if (scl_fall && !oe_ff) begin
						nxt_oe = !nack_ff;
						if (nack_ff) begin
							nxt_st = tsb_pkg::TSB_IDLE;
						end
					end else if (scl_fall) begin
						nxt_oe = 1'b0;
						nxt_bit = tsb_pkg::BIT_MSB;
						nxt_st = tsb_pkg::TSB_WR;
					end
				end
				tsb_pkg::TSB_RD: begin
					if (scl_fall) begin
						nxt_bit = bit_ff - 1'b1;
						nxt_sh = {sh_ff[6:0], 1'b0};
						nxt_oe = (bit_ff != tsb_pkg::BIT_LSB) && !sh_ff[6];
						if (bit_ff == tsb_pkg::BIT_LSB) begin
							nxt_st = tsb_pkg::TSB_RD_ACK;
						end
					end
				end
				tsb_pkg::TSB_RD_ACK: begin
					if (scl_rise) begin
						nxt_nack = sda_ff;
					end else if (scl_fall) begin
						nxt_bit = tsb_pkg::BIT_MSB;
						if (nack_ff) begin
							nxt_st = tsb_pkg::TSB_IDLE;
						end else begin
							nxt_st = tsb_pkg::TSB_RD;
							nxt_sh = rd_data;
							nxt_oe = !rd_data[7];
						end
					end
				end
				default: nxt_st = tsb_pkg::TSB_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_ff <= tsb_pkg::TSB_IDLE;
			sh_ff <= '0;
			bit_ff <= tsb_pkg::BIT_MSB;
			strap_ff <= '0;
			fn_ff <= '0;
			rd_ff <= 1'b0;
			oe_ff <= 1'b0;
			nack_ff <= 1'b0;
			al_ff <= 1'b0;
			hv_ff <= 1'b0;
			start_ff <= 1'b0;
			stop_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			sh_ff <= nxt_sh;
			bit_ff <= nxt_bit;
			strap_ff <= nxt_strap;
			fn_ff <= nxt_fn;
			rd_ff <= nxt_rd;
			oe_ff <= nxt_oe;
			nack_ff <= nxt_nack;
			al_ff <= alarm_req;
			hv_ff <= strap_zero_hv;
			start_ff <= start_det;
			stop_ff <= stop_det;
		end
	end
	tsb_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(push),
		.in_ready(f_ready),
		.in_data({sh_ff[6:0], sda_ff}),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_data)
	);
	assign sda_out = 1'b0;
	assign sda_oe = oe_ff;
	assign alarm_out = 1'b0;
	assign alarm_oe = al_ff;
	assign prot_qual = hv_ff;
	assign acc_fn = fn_ff;
	assign acc_read = rd_ff;
	assign acc_start = start_ff;
	assign acc_stop = stop_ff;
	assign rd_take = (st_ff == tsb_pkg::TSB_RD_ACK) && scl_fall && !nack_ff;
endmodule
`default_nettype wire

// ===== test/tsb_chk_sva.sv
// Purpose: port checks for tsb_target
// Assumes: one clock domain, sync reset
// Notes: bound to every tsb_target
`timescale 1ns/10ps
`default_nettype none
module tsb_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic strap_zero_hv,
	input wire logic prot_qual,
	input wire logic alarm_req,
	input wire logic alarm_out,
	input wire logic alarm_oe,
	input wire logic acc_start,
	input wire logic acc_stop,
	input wire logic rd_take
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sda_high_a: assert property (!sda_out) else $error("sda high");
	alarm_high_a: assert property (!alarm_out) else $error("alarm high");
	alarm_on_a: assert property (alarm_req |=> alarm_oe) else $error("no pull");
	alarm_off_a: assert property (!alarm_req |=> !alarm_oe) else $error("pull");
	prot_copy_a: assert property (1'b1 |=> prot_qual == $past(strap_zero_hv))
		else $error("prot_qual lag");
	start_pulse_a: assert property (acc_start |=> !acc_start) else $error("start");
	// a start must come from a settled level, not a short spike
	start_clean_a: assert property (acc_start |-> $past(scl_in, 3) && !$past(sda_in, 3))
		else $error("early start");
	take_pulse_a: assert property (rd_take |=> !rd_take) else $error("take");
	stop_rel_a: assert property (acc_stop |=> !acc_stop && !sda_oe)
		else $error("held after stop");
	cover property (acc_start);
	cover property (acc_stop);
	cover property (rd_take);
endmodule
bind tsb_target tsb_chk u_chk (.clk, .rst_n, .scl_in, .sda_in, .sda_out,
	.sda_oe, .strap_zero_hv, .prot_qual, .alarm_req, .alarm_out, .alarm_oe,
	.acc_start, .acc_stop, .rd_take);
`default_nettype wire

// ===== test/tsb_host.sv
// Purpose: bus master model making clock and data
// Assumes: pull-ups on both lines, 125 ns bus period
// Notes: clock stands high between frames
`timescale 1ns/10ps
`default_nettype none
module tsb_host (
	output logic scl_low,
	output logic sda_low,
	input wire logic sda
);
	localparam realtime HALF = 62.5;
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	// long high before the first fall so the target's filter settles
	task automatic start();
		sda_low = 1'b1;
		#(2 * HALF);
		scl_low = 1'b1;
		#(HALF / 2);
	endtask
	// data moves mid-low; sampled just before the next fall
	task automatic bit_x(input logic b, output logic r);
		sda_low = !b;
		#(HALF / 2);
		scl_low = 1'b0;
		#(HALF - 1);
		r = sda;
		#1;
		scl_low = 1'b1;
		#(HALF / 2);
	endtask
	task automatic byte_x(input logic [7:0] b, input logic last,
		output logic [7:0] r, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_x(b[i], a);
			r[i] = a;
		end
		bit_x(last, a);
		ack = !a;
	endtask
	task automatic stop();
		sda_low = 1'b1;
		#(HALF / 2);
		scl_low = 1'b0;
		#HALF;
		sda_low = 1'b0;
		#HALF;
	endtask
endmodule
`default_nettype wire

// ===== test/tsb_target_test.sv
// Purpose: self-checking bench for tsb_target
// Assumes: host model on the far side
// Notes: written bytes are checked through a queue
`timescale 1ns/10ps
`default_nettype none
module tsb_target_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic scl_low, sda_low, sda_out, sda_oe, prot_qual, alarm_out, alarm_oe;
	logic acc_read, acc_start, acc_stop, rx_valid, rd_take;
	logic [1:0] acc_fn;
	logic [7:0] rx_data, rd_data = 8'h00;
	logic [2:0] st = 3'h0;
	logic hv = 1'b0, alarm_req = 1'b0, rx_ready = 1'b0, stall = 1'b1;
	logic [7:0] exp_q[$];
	int fails = 0, num_checks = 0, takes = 0;
	wire sda = !(sda_low || sda_oe);
	always #5 clk = ~clk;
	tsb_host u_tsb_host (.scl_low, .sda_low, .sda);
	tsb_target u_tsb_target (.clk, .rst_n, .scl_in(!scl_low), .sda_in(sda),
		.sda_out, .sda_oe, .addr_strap_bit_zero(st[0]),
		.addr_strap_bit_one(st[1]), .addr_strap_bit_two(st[2]),
		.strap_zero_hv(hv), .prot_qual, .alarm_req, .alarm_out, .alarm_oe,
		.acc_fn, .acc_read, .acc_start, .acc_stop, .rx_valid, .rx_ready,
		.rx_data, .rd_data, .rd_take);
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic acc(input logic [6:0] a, input logic rd, output logic ack);
		logic [7:0] r;
		u_tsb_host.start();
		u_tsb_host.byte_x({a, rd}, 1'b1, r, ack);
	endtask
	always @(negedge clk) rx_ready <= stall ? 1'b0 : 1'($urandom);
	always @(posedge clk) begin
		if (rd_take === 1'b1) takes++;
		if (rx_valid === 1'b1 && rx_ready) begin
			check(rx_data, exp_q.size() ? exp_q.pop_front() : 8'hXX);
		end
	end
	initial begin
		#300_000;
		fails++;
		tally_and_finish();
	end
	initial begin
		logic [7:0] d, r;
		logic ack, ex;
		logic [3:0] pfx;
		logic [1:0] k;
		void'($urandom(83));
		repeat (3) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		repeat (10) @(negedge clk);
		// every prefix, fresh straps per access, wrong straps and prefix
		for (int i = 0; i < 12; i++) begin
			@(negedge clk);
			{st, hv, alarm_req} = 5'($urandom);
			rd_data = 8'($urandom);
			k = 2'(i % 4);
			pfx = k == 0 ? tsb_pkg::PFX_TEMP : k == 1 ? tsb_pkg::PFX_STORE :
				k == 2 ? tsb_pkg::PFX_PROT : 4'h5;
			ex = k != 2'h3 && (i < 4 || i > 6);
			acc({pfx, st ^ 3'(i > 3 && i < 7)}, i[0], ack);
			check(ack, ex);
			if (ex) begin
				check(acc_fn, k + 2'(tsb_pkg::TSB_FN_TEMP));
				check(acc_read, i[0]);
			end
			if (ex && i[0]) begin
				u_tsb_host.byte_x(8'hFF, 1'b1, r, ack);
				check(r, rd_data);
			end
			u_tsb_host.stop();
			check(alarm_oe, alarm_req);
			check(prot_qual, hv);
		end
		$display("addressing test done");
		@(negedge clk) stall = 1'b0;
		acc({tsb_pkg::PFX_STORE, st}, 1'b0, ack);
		for (int j = 0; j < 5; j++) begin
			d = 8'($urandom);
			exp_q.push_back(d);
			u_tsb_host.byte_x(d, 1'b1, r, ack);
			check(ack, 1'b1);
		end
		u_tsb_host.stop();
		takes = 0;
		acc({tsb_pkg::PFX_TEMP, st}, 1'b1, ack);
		u_tsb_host.byte_x(8'hFF, 1'b0, r, ack);
		check(r, rd_data);
		u_tsb_host.byte_x(8'hFF, 1'b1, r, ack);
		check(r, rd_data);
		u_tsb_host.stop();
		check(8'(takes), 8'h01);
		$display("stream test done");
		for (int n = 0; n < 2000 && exp_q.size() > 0; n++) @(posedge clk);
		@(negedge clk) stall = 1'b1;
		acc({tsb_pkg::PFX_STORE, st}, 1'b0, ack);
		for (int j = 0; j <= tsb_pkg::FIFO_DEPTH; j++) begin
			d = 8'($urandom);
			u_tsb_host.byte_x(d, 1'b1, r, ack);
			check(ack, j < tsb_pkg::FIFO_DEPTH);
			if (ack === 1'b1) exp_q.push_back(d);
		end
		u_tsb_host.stop();
		@(negedge clk) stall = 1'b0;
		for (int n = 0; n < 2000 && exp_q.size() > 0; n++) @(posedge clk);
		check(8'(exp_q.size()), 8'h00);
		$display("buffer test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
